// >>> dv/tb_top.sv
// self-checking bench of the two-wire potentiometer slave
`timescale 1ns/1ps

module tb_top;
  localparam int unsigned WR_CYC = 300; // short, yet longer than one poll
  logic clk_i, sys_rst_i, supply_ok_i, write_enable_latch_i, scl, sda_rel, sda_o, sda_oe_o;
  logic nv_wr_o, csr_wr_o, write_busy_o, recall_done_o, ack;
  logic [1:0] nv_wr_sel_o;
  logic [5:0] w0;
  logic [6:0] w1;
  logic [7:0] w2, nv_wr_data_o, csr_wr_data_o, rd_b;
  logic [63:0] t0;
  logic [99:0] t1;
  logic [255:0] t2;
  wire logic sda_line;
  int num_errors = 0, num_checks = 0, cyc = 0, nv_pulses = 0, csr_pulses = 0;

  // pulled-up wire, low while either side pulls
  assign sda_line = sda_rel & ~(sda_oe_o & ~sda_o);

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  twp_master_model mst_u (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_rel_o(sda_rel));
  twp_slave #(.WRITE_CYCLES(WR_CYC), .SETTLE_CYCLES(20)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .supply_ok_i(supply_ok_i), .nv_wiper0_i(6'h2A), .nv_wiper1_i(7'h50),
    .nv_wiper2_i(8'h7C), .nv_wr_o(nv_wr_o), .nv_wr_sel_o(nv_wr_sel_o),
    .nv_wr_data_o(nv_wr_data_o), .write_enable_latch_i(write_enable_latch_i),
    .csr_rd_data_i(8'hC5), .csr_wr_o(csr_wr_o), .csr_wr_data_o(csr_wr_data_o),
    .write_busy_o(write_busy_o), .recall_done_o(recall_done_o), .wiper0_pos_o(w0),
    .wiper1_pos_o(w1), .wiper2_pos_o(w2), .tap0_en_o(t0), .tap1_en_o(t1), .tap2_en_o(t2));

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // pulse counts; a ceiling far above the run cuts a hang
  always @(posedge clk_i) begin
    cyc++;
    if (nv_wr_o === 1'b1) nv_pulses++;
    if (csr_wr_o === 1'b1) csr_pulses++;
    if (cyc == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic wait_idle();
    for (int i = 0; i < 2000 && write_busy_o !== 1'b0; i++) @(posedge clk_i);
  endtask : wait_idle

  // wiper value and its tap switch
  task automatic chk_pot(input int p, input logic [7:0] e);
    logic [7:0] pos;
    logic tap;
    pos = (p == 0) ? {2'h0, w0} : (p == 1) ? {1'h0, w1} : w2;
    tap = (p == 0) ? t0[e[5:0]] : (p == 1) ? t1[e[6:0]] : t2[e];
    check("wiper", pos, e);
    check("tap", {7'h00, tap}, 8'h01);
  endtask : chk_pot

  // three-byte pot write; ok if every byte was acknowledged
  task automatic pot_wr(input logic [7:0] ins, input logic [7:0] dat, output logic ok);
    logic a1, a2, a3;
    mst_u.start_cond();
    mst_u.send_byte(8'hAE, a1);
    mst_u.send_byte(ins, a2);
    mst_u.send_byte(dat, a3);
    mst_u.stop_cond();
    ok = a1 & a2 & a3;
  endtask : pot_wr

  task automatic s_power();
    check("w0 init", {2'h0, w0}, 8'h3F);
    check("w2 init", w2, 8'hFF);
    supply_ok_i <= 1'b1;
    mst_u.start_cond();
    mst_u.send_byte(8'hAE, ack);
    mst_u.stop_cond();
    check("early ack", 8'(ack), 8'h00);
    for (int i = 0; i < 200 && recall_done_o !== 1'b1; i++) @(posedge clk_i);
    chk_pot(0, 8'h2A);
    chk_pot(1, 8'h50);
    chk_pot(2, 8'h7C);
  endtask : s_power

  task automatic s_addr();
    logic [7:0] tbl [6] = '{8'hBE, 8'hA2, 8'hAC, 8'hA8, 8'hAE, 8'hA4};
    logic [5:0] acks = 6'h30;
    foreach (tbl[i]) begin
      mst_u.start_cond();
      mst_u.send_byte(tbl[i], ack);
      mst_u.stop_cond();
      check("addr ack", 8'(ack), 8'(acks[i]));
      wait_idle();
    end
  endtask : s_addr

  task automatic s_vol();
    logic [7:0] din [3] = '{8'h80, 8'hC8, 8'h5A};
    logic [7:0] dexp [3] = '{8'h3F, 8'h63, 8'h5A};
    logic ok;
    write_enable_latch_i <= 1'b1;
    foreach (din[p]) begin
      pot_wr({6'h00, 2'(p)}, din[p], ok);
      check("wr ack", 8'(ok), 8'h01);
      chk_pot(p, dexp[p]);
    end
    check("nv idle", 8'(nv_pulses), 8'h00);
    pot_wr(8'h03, 8'h10, ok);
    check("pot3 ack", 8'(ok), 8'h00);
    write_enable_latch_i <= 1'b0;
    pot_wr(8'h02, 8'h11, ok);
    check("locked ack", 8'(ok), 8'h01);
    chk_pot(2, 8'h5A);
  endtask : s_vol

  task automatic s_nv();
    logic ok;
    write_enable_latch_i <= 1'b1;
    pot_wr(8'h81, 8'h33, ok);
    repeat (8) @(posedge clk_i);
    check("nv pulse", 8'(nv_pulses), 8'h01);
    check("nv sel", {6'h00, nv_wr_sel_o}, 8'h01);
    check("nv data", nv_wr_data_o, 8'h33);
    chk_pot(1, 8'h33);
    mst_u.start_cond();
    mst_u.send_byte(8'hAF, ack);
    mst_u.stop_cond();
    check("busy poll", 8'(ack), 8'h00);
    wait_idle();
    mst_u.start_cond();
    mst_u.send_byte(8'hAE, ack);
    mst_u.stop_cond();
    check("idle poll", 8'(ack), 8'h01);
  endtask : s_nv

  task automatic s_read();
    logic a1, a2;
    mst_u.start_cond();
    mst_u.send_byte(8'hAE, a1);
    mst_u.send_byte(8'h02, a2);
    mst_u.start_cond();
    mst_u.send_byte(8'hAF, ack);
    check("rd ack", 8'(a1 & a2 & ack), 8'h01);
    mst_u.get_byte(1'b1, rd_b);
    check("rd 1", rd_b, 8'h5A);
    mst_u.get_byte(1'b0, rd_b);
    check("rd 2", rd_b, 8'h5A);
    mst_u.stop_cond();
    check("released", 8'(sda_oe_o), 8'h00);
    mst_u.start_cond();
    mst_u.send_byte(8'hA5, ack);
    mst_u.get_byte(1'b0, rd_b);
    mst_u.stop_cond();
    check("csr rd", rd_b, 8'hC5);
    mst_u.start_cond();
    mst_u.send_byte(8'hA4, ack);
    mst_u.send_byte(8'h3C, ack);
    mst_u.stop_cond();
    check("csr wr", csr_wr_data_o, 8'h3C);
    check("csr pulse", 8'(csr_pulses), 8'h01);
  endtask : s_read

  // reset, then the scenarios
  initial begin
    sys_rst_i = 1'b1;
    supply_ok_i = 1'b0;
    write_enable_latch_i = 1'b0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    s_power();
    s_addr();
    s_vol();
    s_nv();
    s_read();
    tally_and_finish();
  end
endmodule : tb_top

// >>> dv/twp_master_model.sv
// bus master model: clocks the link and drives the data line open drain
`timescale 1ns/1ps

module twp_master_model (
  // clock
  input wire logic clk_i,
  // two-wire link
  input wire logic sda_line_i,
  output logic scl_o,
  output logic sda_rel_o
);
  // clock stands high between frames; master alone clocks the link
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end

  // one bit: six cycles low so the slave's reply settles before the rise
  task automatic put_bit(input logic b, output logic s);
    @(posedge clk_i);
    sda_rel_o <= b;
    repeat (5) @(posedge clk_i);
    scl_o <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    s = sda_line_i;
    @(posedge clk_i);
    scl_o <= 1'b0;
  endtask : put_bit

  // start or repeated start: data falls with clock high
  task automatic start_cond();
    @(posedge clk_i);
    sda_rel_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_rel_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    scl_o <= 1'b0;
  endtask : start_cond

  // stop: data rises with clock high; clock stays high
  task automatic stop_cond();
    @(posedge clk_i);
    sda_rel_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    sda_rel_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : stop_cond

  // eight bits out, then a released ninth bit for the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // eight bits in, then the master's acknowledge or none
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(~mack, s);
  endtask : get_byte
endmodule : twp_master_model

// >>> dv/twp_slave_monitor.sv
// port checker of the potentiometer slave, bound to its top
`timescale 1ns/1ps
`include "twp_regs.svh"

module twp_slave_monitor #(
  parameter int unsigned WRITE_CYCLES = 50,
  parameter int unsigned SETTLE_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // link, supply and status
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic supply_ok_i,
  input wire logic nv_wr_o,
  input wire logic write_busy_o,
  input wire logic recall_done_o,
  // wipers and tap switches
  input wire logic [5:0] wiper0_pos_o,
  input wire logic [6:0] wiper1_pos_o,
  input wire logic [7:0] wiper2_pos_o,
  input wire logic [255:0] tap2_en_o
);
  int unsigned busy_cnt_r;
  int unsigned sup_cnt_r;

  default clocking mon_cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // run lengths, too long for repetition
  always_ff @(posedge clk_i) begin
    busy_cnt_r <= write_busy_o ? busy_cnt_r + 1 : 0;
    sup_cnt_r <= supply_ok_i ? sup_cnt_r + 1 : 0;
  end

  pre_recall_quiet_a: assert property (!recall_done_o |-> !sda_oe_o)
    else $error("data line driven before recall");
  drive_clock_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while clock high");
  busy_silent_a: assert property (write_busy_o |-> !sda_oe_o)
    else $error("acknowledge given while busy");
  nv_pulse_busy_a: assert property (nv_wr_o |=> !nv_wr_o && write_busy_o)
    else $error("store write without busy cycle");
  busy_length_a: assert property ($fell(write_busy_o) |->
    busy_cnt_r + 2 >= WRITE_CYCLES && busy_cnt_r <= WRITE_CYCLES + 2)
    else $error("busy cycle length wrong");
  recall_settle_a: assert property ($rose(recall_done_o) |->
    sup_cnt_r >= SETTLE_CYCLES)
    else $error("recall before settle time");
  init_wipers_a: assert property (!recall_done_o |-> wiper0_pos_o == `TWP_INIT_W0 &&
    wiper1_pos_o == `TWP_INIT_W1 && wiper2_pos_o == `TWP_INIT_W2)
    else $error("wiper not at initial value");
  clamp_mid_a: assert property (wiper1_pos_o <= `TWP_MAX_W1)
    else $error("middle wiper above maximum");
  make_break_a: assert property ($changed(tap2_en_o) && $onehot($past(tap2_en_o)) |->
    $countones(tap2_en_o) == 2 ##1 $onehot(tap2_en_o))
    else $error("tap switch broke before make");

  // main scenarios reached
  cover property (nv_wr_o);
  cover property ($fell(write_busy_o));
  cover property ($countones(tap2_en_o) == 2);
endmodule : twp_slave_monitor

bind twp_slave twp_slave_monitor #(
  .WRITE_CYCLES(WRITE_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)) mon_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .supply_ok_i(supply_ok_i), .nv_wr_o(nv_wr_o), .write_busy_o(write_busy_o),
  .recall_done_o(recall_done_o), .wiper0_pos_o(wiper0_pos_o), .wiper1_pos_o(wiper1_pos_o),
  .wiper2_pos_o(wiper2_pos_o), .tap2_en_o(tap2_en_o));

// >>> hw/twp_pkg.sv
// types of the two-wire potentiometer slave
package twp_pkg;

  // ----------------------------------------------------------------
  // bus sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_IGNORE
  } twp_state_t;

  // ----------------------------------------------------------------
  // complete state of the slave top
  // ----------------------------------------------------------------
  typedef struct packed {
    twp_state_t st;
    logic [3:0] bitcnt;
    logic [1:0] byte_idx;
    logic [7:0] shreg;
    logic [7:0] txbyte;
    logic [7:0] instr;
    logic tgt_csr;
    logic rd;
    logic acked;
    logic sda_oe;
    logic sda_out;
    logic scl_d;
    logic sda_d;
    logic nv_pend;
    logic csr_pend;
    logic busy;
    logic [23:0] busy_cnt;
    logic [23:0] settle_cnt;
    logic done;
    logic [5:0] w0;
    logic [6:0] w1;
    logic [7:0] w2;
    logic nv_wr;
    logic [1:0] nv_sel;
    logic [7:0] nv_data;
    logic csr_wr;
    logic [7:0] csr_data;
  } twp_slave_st_t;

endpackage : twp_pkg

// >>> hw/twp_regs.svh
// constants of the two-wire potentiometer slave: codes, reset values, timing counts
`ifndef TWP_REGS_SVH
`define TWP_REGS_SVH

// ----------------------------------------------------------------
// slave address and instruction fields, bits per byte
// ----------------------------------------------------------------
`define TWP_DEV_TYPE 4'hA
`define TWP_SEL_POT 3'h7
`define TWP_SEL_CSR 3'h2
`define TWP_POT_RSVD 2'h3
`define TWP_INSTR_ZERO 5'h00
`define TWP_BYTE_BITS 4'h8

// ----------------------------------------------------------------
// wiper values before recall and clamp maxima
// ----------------------------------------------------------------
`define TWP_INIT_W0 6'h3F
`define TWP_INIT_W1 7'h00
`define TWP_INIT_W2 8'hFF
`define TWP_MAX_W0 8'h3F
`define TWP_MAX_W1 8'h63
`define TWP_MAX_W2 8'hFF

// ----------------------------------------------------------------
// timing: times in microseconds, counts in cycles of clk_i
// ----------------------------------------------------------------
`define TWP_CLK_KHZ 25000
`define TWP_WRITE_TIME_US 5000
`define TWP_SETTLE_TIME_US 1000
`define TWP_WRITE_CYCLES (`TWP_WRITE_TIME_US * `TWP_CLK_KHZ / 1000)
`define TWP_SETTLE_CYCLES ((`TWP_SETTLE_TIME_US * `TWP_CLK_KHZ + 999) / 1000)

`endif

// >>> hw/twp_slave.sv
// two-wire serial slave front end of a triple digital potentiometer
`timescale 1ns/1ps
`include "twp_regs.svh"

// Function
// RULE_01: slave only; the master starts transfers and drives the clock.
// RULE_02: data changes only with clock low; clock-high changes mean start/stop.
// RULE_03: data line released after power-up until a transfer needs it.
// RULE_04: start is data falling with clock high; nothing happens before a start.
// RULE_05: stop is data rising with clock high; it returns to standby.
// RULE_06: after eight bits the transmitter releases; receiver pulls low on ninth clock.
// RULE_07: address byte acknowledged only if its identifier bits match.
// RULE_08: on writes every further received byte is acknowledged; a pot instruction byte with bits 6:2 nonzero or bits 1:0 of 3 gets none.
// RULE_09: reads send eight bits, sample acknowledge, continue on ack, stop on none.
// RULE_10: master answers a missing acknowledge on a read with a stop.
// RULE_11: every operation opens with the address byte: target and direction.
// RULE_12: top four address bits must be 1010 for a response.
// RULE_13: next three bits: 111 potentiometers, 010 control/status, others reserved.
// RULE_14: lowest address bit 1 means read, 0 means write.
// RULE_15: pot writes take effect only while the write enable latch is set.
// RULE_16: a nonvolatile write closed by stop starts a 5 ms busy cycle.
// RULE_17: valid addresses unacknowledged while busy, acknowledged afterwards.
// RULE_18: three wipers of 63, 99 and 255 segments, one tap switch on each.
// RULE_19: volatile wiper registers load from the nonvolatile store at power-up.
// RULE_20: before recall the wipers hold 63, 0 and 255.
// RULE_21: a moving wiper turns the new switch on before the old one off.
// RULE_22: recall only after supply stays above trip level for the settle time.
// RULE_23: instruction bits 1:0 pick the pot, 3 reserved; bit 7 picks nonvolatile.
// RULE_24: data byte lands in the wiper on the clock rise after its last bit.
// RULE_25: data above a wiper maximum clamps to the top tap, no wrap.
// RULE_26: reserved select values: no acknowledge, bus stays released.
// RULE_27: the 100-tap wiper clamps at 99.
module twp_slave #(
  parameter int unsigned WRITE_CYCLES = `TWP_WRITE_CYCLES,
  parameter int unsigned SETTLE_CYCLES = `TWP_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // two-wire bus, data line open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // supply monitor, high while above trip level
  input wire logic supply_ok_i,
  // nonvolatile wiper store
  input wire logic [5:0] nv_wiper0_i,
  input wire logic [6:0] nv_wiper1_i,
  input wire logic [7:0] nv_wiper2_i,
  output logic nv_wr_o,
  output logic [1:0] nv_wr_sel_o,
  output logic [7:0] nv_wr_data_o,
  // control/status register
  input wire logic write_enable_latch_i,
  input wire logic [7:0] csr_rd_data_i,
  output logic csr_wr_o,
  output logic [7:0] csr_wr_data_o,
  // status
  output logic write_busy_o,
  output logic recall_done_o,
  // wiper position registers and tap switches
  output logic [5:0] wiper0_pos_o,
  output logic [6:0] wiper1_pos_o,
  output logic [7:0] wiper2_pos_o,
  output logic [63:0] tap0_en_o,
  output logic [99:0] tap1_en_o,
  output logic [255:0] tap2_en_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] clamp(input logic [7:0] d, input logic [7:0] mx);
    clamp = (d > mx) ? mx : d;
  endfunction : clamp

  twp_pkg::twp_slave_st_t r;
  twp_pkg::twp_slave_st_t n;
  logic [2:0] in_s;
  logic scl_s;
  logic sda_s;
  logic sup_s;

  function automatic logic [7:0] wiper_by_code(input twp_pkg::twp_slave_st_t s,
                                               input logic [1:0] code);
    case (code)
      2'h0: wiper_by_code = {2'h0, s.w0};
      2'h1: wiper_by_code = {1'h0, s.w1};
      default: wiper_by_code = s.w2;
    endcase
  endfunction : wiper_by_code

  // ----------------------------------------------------------------
  // input synchronisers; idle bus reads high, supply reads low
  // ----------------------------------------------------------------
  twp_sync #(
    .W(3),
    .RST_VAL(3'h3)
  ) u_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i({supply_ok_i, sda_i, scl_i}),
    .q_o(in_s)
  );

  assign scl_s = in_s[0];
  assign sda_s = in_s[1];
  assign sup_s = in_s[2];
  // ----------------------------------------------------------------
  // tap switch decoders
  // ----------------------------------------------------------------
  twp_wiper #(.TAPS(64), .PW(6), .INIT(`TWP_INIT_W0)) u_wiper0 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pos_i(r.w0),
    .tap_en_o(tap0_en_o)
  );

  twp_wiper #(.TAPS(100), .PW(7), .INIT(`TWP_INIT_W1)) u_wiper1 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pos_i(r.w1),
    .tap_en_o(tap1_en_o)
  );

  twp_wiper #(.TAPS(256), .PW(8), .INIT(`TWP_INIT_W2)) u_wiper2 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .pos_i(r.w2),
    .tap_en_o(tap2_en_o)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  // bus events from the filtered levels and their previous values
  assign scl_rise = scl_s & ~r.scl_d;
  assign scl_fall = ~scl_s & r.scl_d;
  assign start_seen = r.scl_d & scl_s & r.sda_d & ~sda_s; // [RULE_02] [RULE_04]
  assign stop_seen = r.scl_d & scl_s & ~r.sda_d & sda_s; // [RULE_05]

  always_comb begin
    logic ack;
    logic [7:0] wdat;
    logic [7:0] rdat;
    ack = 1'b0;
    wdat = 8'h00;
    rdat = r.tgt_csr ? csr_rd_data_i : wiper_by_code(r, r.instr[1:0]);
    n = r;
    n.nv_wr = 1'b0;
    n.csr_wr = 1'b0;
    n.scl_d = scl_s;
    n.sda_d = sda_s;

    // power-up recall waits for a settled supply; a dip restarts the wait
    if (!r.done) begin
      if (!sup_s) begin
        n.settle_cnt = '0; // [RULE_22]
      end else if (r.settle_cnt >= 24'(SETTLE_CYCLES - 1)) begin
        n.done = 1'b1;
        n.w0 = 6'(clamp({2'h0, nv_wiper0_i}, `TWP_MAX_W0)); // [RULE_19]
        n.w1 = 7'(clamp({1'h0, nv_wiper1_i}, `TWP_MAX_W1)); // [RULE_19] [RULE_27]
        n.w2 = nv_wiper2_i; // [RULE_19]
      end else begin
        n.settle_cnt = r.settle_cnt + 24'h1;
      end
    end

    // internal write cycle timer
    if (r.busy) begin
      if (r.busy_cnt >= 24'(WRITE_CYCLES - 1)) begin
        n.busy = 1'b0; // [RULE_16]
        n.busy_cnt = '0;
      end else begin
        n.busy_cnt = r.busy_cnt + 24'h1;
      end
    end

    // bus sequencer; the clock only ever comes from the master
    if (!r.done) begin
      n.st = twp_pkg::ST_IDLE; // bus ignored until wipers are recalled
    end else if (start_seen) begin
      n.st = twp_pkg::ST_RX; // [RULE_01] [RULE_04] repeated start restarts too
      n.bitcnt = '0;
      n.byte_idx = 2'h0; // [RULE_11]
      n.sda_oe = 1'b0;
      n.nv_pend = 1'b0;
      n.csr_pend = 1'b0;
    end else if (stop_seen) begin
      n.st = twp_pkg::ST_IDLE; // [RULE_05]
      n.sda_oe = 1'b0;
      n.nv_pend = 1'b0;
      n.csr_pend = 1'b0;
      if (r.nv_pend | r.csr_pend) begin
        n.busy = 1'b1; // [RULE_16]
        n.busy_cnt = '0;
        n.nv_wr = r.nv_pend;
      end
    end else begin
      unique case (r.st)
        twp_pkg::ST_IDLE,
        twp_pkg::ST_IGNORE: begin
          n.sda_oe = 1'b0; // [RULE_03] [RULE_26]
        end
        twp_pkg::ST_RX: begin
          if (scl_rise && r.bitcnt != `TWP_BYTE_BITS) begin
            n.shreg = {r.shreg[6:0], sda_s};
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == `TWP_BYTE_BITS) begin
            unique case (r.byte_idx)
              2'h0: begin
                // address byte: type, select and direction
                ack = (r.shreg[7:4] == `TWP_DEV_TYPE) // [RULE_07] [RULE_12]
                    && (r.shreg[3:1] == `TWP_SEL_POT || r.shreg[3:1] == `TWP_SEL_CSR)
                    && !r.busy; // [RULE_13] [RULE_17] [RULE_26]
                n.tgt_csr = (r.shreg[3:1] == `TWP_SEL_CSR);
                n.rd = r.shreg[0]; // [RULE_14]
              end
              2'h1: begin
                if (r.tgt_csr) begin
                  ack = 1'b1; // [RULE_08]
                end else begin
                  ack = (r.shreg[6:2] == `TWP_INSTR_ZERO)
                      && (r.shreg[1:0] != `TWP_POT_RSVD); // [RULE_23]
                  n.instr = r.shreg;
                end
              end
              default: begin
                ack = 1'b1; // [RULE_08]
              end
            endcase
            n.byte_idx = (r.byte_idx == 2'h3) ? 2'h3 : r.byte_idx + 2'h1;
            n.sda_oe = ack; // [RULE_06] pull low through the ninth clock
            n.st = ack ? twp_pkg::ST_ACK : twp_pkg::ST_IGNORE;
          end
        end
        twp_pkg::ST_ACK: begin
          if (scl_rise && !r.rd) begin
            // writes land on the rise of the ninth clock
            if (r.tgt_csr && r.byte_idx == 2'h2) begin
              n.csr_wr = 1'b1;
              n.csr_data = r.shreg;
              n.csr_pend = 1'b1; // control/status writes also start a write cycle
            end else if (!r.tgt_csr && r.byte_idx == 2'h3 && write_enable_latch_i) begin // [RULE_15]
              unique case (r.instr[1:0])
                2'h0: wdat = clamp(r.shreg, `TWP_MAX_W0); // [RULE_25]
                2'h1: wdat = clamp(r.shreg, `TWP_MAX_W1); // [RULE_27]
                default: wdat = r.shreg; // [RULE_25] top of 8 bits is the top tap
              endcase
              unique case (r.instr[1:0])
                2'h0: n.w0 = wdat[5:0]; // [RULE_24]
                2'h1: n.w1 = wdat[6:0]; // [RULE_24]
                default: n.w2 = wdat; // [RULE_24]
              endcase
              n.nv_pend = r.instr[7]; // [RULE_23] nonvolatile copy waits for stop
              n.nv_sel = r.instr[1:0];
              n.nv_data = wdat;
            end
          end else if (scl_fall) begin
            n.sda_oe = 1'b0; // [RULE_06]
            n.bitcnt = '0;
            n.st = twp_pkg::ST_RX;
            if (r.rd) begin
              n.txbyte = rdat;
              n.sda_oe = ~rdat[7];
              n.bitcnt = 4'h1;
              n.st = twp_pkg::ST_TX; // [RULE_09]
            end
          end
        end
        twp_pkg::ST_TX: begin
          if (scl_fall) begin
            if (r.bitcnt == `TWP_BYTE_BITS) begin
              n.sda_oe = 1'b0; // [RULE_06] [RULE_09] release for the master's answer
              n.acked = 1'b0;
              n.st = twp_pkg::ST_TXACK;
            end else begin
              n.sda_oe = ~r.txbyte[3'h7 - r.bitcnt[2:0]]; // [RULE_02] change with clock low
              n.bitcnt = r.bitcnt + 4'h1;
            end
          end
        end
        twp_pkg::ST_TXACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              n.st = twp_pkg::ST_IGNORE; // [RULE_09] [RULE_10] wait for the master's stop
            end else begin
              n.acked = 1'b1;
            end
          end else if (scl_fall && r.acked) begin
            n.txbyte = rdat; // [RULE_09]
            n.sda_oe = ~rdat[7];
            n.bitcnt = 4'h1;
            n.acked = 1'b0;
            n.st = twp_pkg::ST_TX;
          end
        end
        default: begin
          n.st = twp_pkg::ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register; data line released from reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= '0; // idle, data line released [RULE_03]
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.w0 <= `TWP_INIT_W0; // [RULE_20]
      r.w1 <= `TWP_INIT_W1; // [RULE_20]
      r.w2 <= `TWP_INIT_W2; // [RULE_20]
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign sda_o = r.sda_out;
  assign sda_oe_o = r.sda_oe;
  assign nv_wr_o = r.nv_wr;
  assign nv_wr_sel_o = r.nv_sel;
  assign nv_wr_data_o = r.nv_data;
  assign csr_wr_o = r.csr_wr;
  assign csr_wr_data_o = r.csr_data;
  assign write_busy_o = r.busy;
  assign recall_done_o = r.done;
  assign wiper0_pos_o = r.w0;
  assign wiper1_pos_o = r.w1;
  assign wiper2_pos_o = r.w2;

endmodule : twp_slave

// >>> hw/twp_sync.sv
// three-flop input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps

module twp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // raw and filtered levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } twp_sync_st_t;

  twp_sync_st_t r;
  twp_sync_st_t n;

  // ----------------------------------------------------------------
  // stage one feeds only stage two; output moves on agreement
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.s1 = d_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q); // one-cycle glitches drop out
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign q_o = r.q;

endmodule : twp_sync

// >>> hw/twp_wiper.sv
// tap switch decoder of one wiper with make-before-break switching
`timescale 1ns/1ps

module twp_wiper #(
  parameter int TAPS = 64,
  parameter int PW = 6,
  parameter logic [PW-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // wiper position and tap switch enables
  input wire logic [PW-1:0] pos_i,
  output logic [TAPS-1:0] tap_en_o
);

  typedef struct packed {
    logic [PW-1:0] pos_d;
    logic [TAPS-1:0] en;
  } twp_wiper_st_t;

  twp_wiper_st_t r;
  twp_wiper_st_t n;

  function automatic logic [TAPS-1:0] onehot(input logic [PW-1:0] p);
    onehot = {{(TAPS-1){1'b0}}, 1'b1} << p;
  endfunction : onehot

  // ----------------------------------------------------------------
  // for one cycle after a move both old and new taps are on
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.pos_d = pos_i;
    n.en = onehot(pos_i) | onehot(r.pos_d); // [RULE_21] new switch on before old one drops
  end

  // state register, one tap on from reset
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      r <= '{pos_d: INIT, en: onehot(INIT)}; // [RULE_18]
    end else begin
      r <= n;
    end
  end

  assign tap_en_o = r.en;

endmodule : twp_wiper
